// ==== src/spd_regs.svh ====
// Constants for the split-port burst SRAM pin model and its controller.
// Assumes one system clock; the link clock is a level toggled by the controller.
`ifndef SPD_REGS_SVH
`define SPD_REGS_SVH

// Array geometry
`define SPD_ADDR_W 19
`define SPD_DATA_W 36
`define SPD_LANES 4
`define SPD_LANE_W 9
`define SPD_BURST 4
`define SPD_BEAT_W 2

// Beat positions within a burst
`define SPD_BEAT_FIRST 2'h0
`define SPD_BEAT_LAST 2'h3

// Idle levels of the active-low selects
`define SPD_SEL_IDLE 1'b1
`define SPD_LANES_IDLE 4'hf

// System clock period in ns
`define SPD_CLK_NS 50

// Read return buffer depth, in whole bursts
`define SPD_FIFO_DEPTH 2

`endif

// ==== src/spd_pkg.sv ====
// Types shared by the SRAM pin model, the controller and the link.
// Assumes the constants header is on the include path.
`include "spd_regs.svh"
package spd_pkg;
  typedef logic [`SPD_ADDR_W-1:0] spd_addr_t;
  typedef logic [`SPD_DATA_W-1:0] spd_word_t;
  typedef logic [`SPD_LANES-1:0] spd_lane_t;
  typedef logic [`SPD_BEAT_W-1:0] spd_beat_t;
  typedef logic [`SPD_BURST*`SPD_DATA_W-1:0] spd_burst_t;
  typedef logic [`SPD_BURST*`SPD_LANES-1:0] spd_bsel_t;
  // Read launch sequencer of the SRAM end
  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_BURST} spd_rd_e;
  // Command sequencer of the controller end
  typedef enum logic {CT_IDLE, CT_WR} spd_ctl_e;
endpackage

// ==== src/spd_link_if.sv ====
// Pin-level link between the SRAM end and the controller end.
// Assumes both ends run on the same system clock; the read bus reads zero when undriven.
`timescale 1ns/1ps
`include "spd_regs.svh"
interface spd_link_if;
  import spd_pkg::*;
  logic k; // True clock level; low phase stands for the complementary edge
  spd_addr_t addr; // Shared address bus
  logic wsel_n; // Write port select
  logic rsel_n; // Read port select
  spd_lane_t bws_n; // Byte lane write selects
  spd_word_t d; // Write data
  spd_word_t q_o; // Read data as driven by the SRAM end
  logic q_oe; // Read data drive enable
  logic vld; // Read beat valid flag
  logic echo; // Echo strobe
  wire [`SPD_DATA_W-1:0] q; // Resolved read bus

  // Released bus shows zero; q_oe low marks the floating state
  assign q = q_oe ? q_o : '0;

  modport dev (input k, addr, wsel_n, rsel_n, bws_n, d, output q_o, q_oe, vld, echo);
  modport ctl (output k, addr, wsel_n, rsel_n, bws_n, d, input q, vld, echo);
endinterface

// ==== src/spd_sram_dev.sv ====
// SRAM end: burst memory with separate write and read data ports.
// Assumes the controller toggles the clock level every system cycle and
// keeps its selects high outside the true-edge cycles it uses.
`timescale 1ns/1ps
`include "spd_regs.svh"
module spd_sram_dev #(
  parameter int MEM_AW = `SPD_ADDR_W // Address bits actually backed by storage
) (
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  spd_link_if.dev LINK,
  output logic WR_BUSY_O,
  output logic RD_BUSY_O
);
  import spd_pkg::*;

  // Storage size in words and index width
  localparam int DEPTH = (1 << MEM_AW) * `SPD_BURST;
  localparam int IW = MEM_AW + `SPD_BEAT_W;

  // Refuse address widths the storage cannot serve
  if (MEM_AW < 1 || MEM_AW > `SPD_ADDR_W) begin : g_bad_aw
    $error("MEM_AW must lie between 1 and the address bus width");
  end

  // Write side state
  logic wr_act_r; // Write burst in progress
  spd_beat_t wr_beat_r; // Beat being captured
  logic [MEM_AW-1:0] wr_addr_r; // Latched write location
  logic [IW-1:0] wr_idx; // Word index of the current write beat

  // Read side state
  spd_rd_e rd_st_r; // Read launch sequencer
  spd_beat_t rd_beat_r; // Beat to launch next
  logic [MEM_AW-1:0] rd_addr_r; // Latched read location
  logic [IW-1:0] rd_idx; // Word index of the next read beat
  spd_word_t rd_word; // Array output for that index

  // Output flops
  spd_word_t q_r; // Read data
  logic q_oe_r; // Read data drive enable
  logic vld_r; // Read beat valid
  logic echo_r; // Echo strobe

  // Request decode
  logic wr_take; // Write starts at this true edge
  logic rd_take; // Read starts at this true edge

  // Write starts only on a true edge, when idle or on its last beat
  assign wr_take = LINK.k && !LINK.wsel_n
    && (!wr_act_r || wr_beat_r == `SPD_BEAT_LAST);

  // Read starts only on a true edge, when idle or on its last launch
  assign rd_take = LINK.k && !LINK.rsel_n
    && (rd_st_r == RD_IDLE || (rd_st_r == RD_BURST && rd_beat_r == `SPD_BEAT_LAST));

  // Word indices: location in the high bits, beat in the low bits
  assign wr_idx = {wr_addr_r, wr_beat_r};
  assign rd_idx = {rd_addr_r, rd_beat_r};

  // Write burst tracking
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wr_act_r <= 1'b0;
      wr_beat_r <= `SPD_BEAT_FIRST;
      wr_addr_r <= '0;
    end else begin
      if (wr_take) begin
        // Address taken only when the write port is selected
        wr_act_r <= 1'b1;
        wr_beat_r <= `SPD_BEAT_FIRST;
        wr_addr_r <= LINK.addr[MEM_AW-1:0];
      end else if (wr_act_r) begin
        // Advance one beat per clock edge, true or complementary
        wr_beat_r <= wr_beat_r + 2'h1;
        // Burst done: port returns to deselected, data ignored
        if (wr_beat_r == `SPD_BEAT_LAST) begin
          wr_act_r <= 1'b0;
        end
      end
    end
  end

  // Storage, one array per byte lane
  for (genvar l = 0; l < `SPD_LANES; l++) begin : g_lane
    logic [`SPD_LANE_W-1:0] mem [0:DEPTH-1]; // Lane storage

    // Lane written only when active and its select is low this beat
    always_ff @(posedge SYS_CLK_I) begin
      if (wr_act_r && !LINK.bws_n[l]) begin
        mem[wr_idx] <= LINK.d[l*`SPD_LANE_W +: `SPD_LANE_W];
      end
    end

    // Lane slice of the read word
    assign rd_word[l*`SPD_LANE_W +: `SPD_LANE_W] = mem[rd_idx];
  end

  // Read launch sequencer
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rd_st_r <= RD_IDLE;
      rd_beat_r <= `SPD_BEAT_FIRST;
      rd_addr_r <= '0;
    end else begin
      case (rd_st_r)
        // Waiting for a selected true edge
        RD_IDLE: begin
          if (rd_take) begin
            rd_st_r <= RD_WAIT;
            rd_beat_r <= `SPD_BEAT_FIRST;
            rd_addr_r <= LINK.addr[MEM_AW-1:0];
          end
        end
        // One half cycle of latency before the first launch
        RD_WAIT: begin
          rd_st_r <= RD_BURST;
          rd_beat_r <= rd_beat_r + 2'h1;
        end
        // Launching the remaining beats
        RD_BURST: begin
          if (rd_beat_r != `SPD_BEAT_LAST) begin
            rd_beat_r <= rd_beat_r + 2'h1;
          end else if (rd_take) begin
            // Back-to-back read: next burst follows without a gap
            rd_st_r <= RD_WAIT;
            rd_beat_r <= `SPD_BEAT_FIRST;
            rd_addr_r <= LINK.addr[MEM_AW-1:0];
          end else begin
            // Pending access done; last beat driven at this edge, outputs float after the next edge
            rd_st_r <= RD_IDLE;
            rd_beat_r <= `SPD_BEAT_FIRST;
          end
        end
        // Unused encoding
        default: begin
          rd_st_r <= RD_IDLE;
          rd_beat_r <= `SPD_BEAT_FIRST;
        end
      endcase
    end
  end

  // Read data drive, one beat per edge of either clock
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      q_r <= '0;
      q_oe_r <= 1'b0;
    end else if (rd_st_r != RD_IDLE) begin
      // Launch the addressed word and drive the bus
      q_r <= rd_word;
      q_oe_r <= 1'b1;
    end else begin
      // Deselected: release the bus
      q_r <= '0;
      q_oe_r <= 1'b0;
    end
  end

  // Valid flag, launched on the same edge as the data it marks
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      vld_r <= 1'b0;
    end else begin
      vld_r <= (rd_st_r != RD_IDLE);
    end
  end

  // Echo strobe, free running, in step with the true clock
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      echo_r <= 1'b0;
    end else begin
      // Clock level toggles each cycle, so its inverse is next level
      echo_r <= !LINK.k;
    end
  end

  // Link outputs straight from flops
  assign LINK.q_o = q_r;
  assign LINK.q_oe = q_oe_r;
  assign LINK.vld = vld_r;
  assign LINK.echo = echo_r;

  // Status outputs straight from flops
  assign WR_BUSY_O = wr_act_r;
  assign RD_BUSY_O = q_oe_r;
endmodule

// ==== src/spd_sram_ctl.sv ====
// Controller end: makes the link clock, issues write and read bursts.
// Assumes the user keeps a request valid until it is taken; read bursts
// return through a small buffer that the user may stall.
`timescale 1ns/1ps
`include "spd_regs.svh"
module spd_sram_ctl #(
  parameter int FIFO_DEPTH = `SPD_FIFO_DEPTH, // Bursts held for the user
  parameter int FIFO_W = `SPD_BURST * `SPD_DATA_W // Bits per held burst
) (
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  spd_link_if.ctl LINK,
  input wire logic WR_VALID_I,
  output logic WR_READY_O,
  input wire spd_pkg::spd_addr_t WR_ADDR_I,
  input wire spd_pkg::spd_burst_t WR_DATA_I,
  input wire spd_pkg::spd_bsel_t WR_BSEL_N_I,
  input wire logic RD_VALID_I,
  output logic RD_READY_O,
  input wire spd_pkg::spd_addr_t RD_ADDR_I,
  output spd_pkg::spd_burst_t RD_DATA_O,
  output logic RD_DATA_VALID_O,
  input wire logic RD_DATA_READY_I
);
  import spd_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH + 1); // Buffer count width

  // Refuse buffer shapes the logic cannot serve
  if (FIFO_DEPTH < 1 || FIFO_W != `SPD_BURST * `SPD_DATA_W) begin : g_bad_fifo
    $error("FIFO_DEPTH must be at least 1 and FIFO_W one whole burst");
  end

  // Link drive flops
  logic k_r; // Clock level
  logic wsel_n_r; // Write select
  logic rsel_n_r; // Read select
  spd_addr_t addr_r; // Address
  spd_word_t d_r; // Write data beat
  spd_lane_t bws_n_r; // Lane selects of the beat

  // Command sequencer
  spd_ctl_e st_r; // Idle or writing
  spd_beat_t wb_r; // Write beat to present next
  spd_burst_t wdata_r; // Latched write burst
  spd_bsel_t wbsel_r; // Latched lane selects
  logic wr_rdy_r; // Write request ready
  logic rd_rdy_r; // Read request ready
  logic wr_take; // Write request taken
  logic rd_take; // Read request taken

  // Read return path
  logic pend_r; // Read burst outstanding
  spd_beat_t rb_r; // Returning beat count
  spd_burst_t asm_r; // Burst being assembled
  logic push; // Whole burst ready for the buffer
  spd_burst_t push_data; // That burst
  spd_burst_t ent_r [FIFO_DEPTH]; // Buffer entries, head at 0
  logic [CW-1:0] cnt_r; // Entries held
  logic [CW-1:0] cnt_nxt; // Entries after this edge
  logic [CW-1:0] slot; // Entry that a push fills
  logic ovld_r; // Head entry valid
  logic pop; // Head taken by the user

  assign wr_take = WR_VALID_I && wr_rdy_r;
  assign rd_take = RD_VALID_I && rd_rdy_r;

  // Readiness, offered only in the cycle before a true edge
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wr_rdy_r <= 1'b0;
      rd_rdy_r <= 1'b0;
    end else begin
      // Writes first; one access per true edge on the shared address
      wr_rdy_r <= k_r && st_r == CT_IDLE && WR_VALID_I;
      // Read only with room for its whole burst
      rd_rdy_r <= k_r && st_r == CT_IDLE && !WR_VALID_I && RD_VALID_I
        && !pend_r && cnt_r < CW'(FIFO_DEPTH);
    end
  end

  // Clock, selects and address
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      k_r <= 1'b0;
      wsel_n_r <= `SPD_SEL_IDLE;
      rsel_n_r <= `SPD_SEL_IDLE;
      addr_r <= '0;
    end else begin
      // Clock divider: one link clock every two system cycles
      k_r <= !k_r;
      // Selects stand for exactly one true-edge cycle
      wsel_n_r <= !wr_take;
      rsel_n_r <= !rd_take;
      if (wr_take) begin
        addr_r <= WR_ADDR_I;
      end else if (rd_take) begin
        addr_r <= RD_ADDR_I;
      end
    end
  end

  // Write burst sequencer
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_r <= CT_IDLE;
      wb_r <= `SPD_BEAT_FIRST;
      wdata_r <= '0;
      wbsel_r <= '0;
      d_r <= '0;
      bws_n_r <= `SPD_LANES_IDLE;
    end else begin
      case (st_r)
        // Latch the burst when a write is taken
        CT_IDLE: begin
          bws_n_r <= `SPD_LANES_IDLE;
          if (wr_take) begin
            st_r <= CT_WR;
            wb_r <= `SPD_BEAT_FIRST;
            wdata_r <= WR_DATA_I;
            wbsel_r <= WR_BSEL_N_I;
          end
        end
        // Beats follow the select on successive clock edges, true and complementary
        CT_WR: begin
          d_r <= wdata_r[wb_r*`SPD_DATA_W +: `SPD_DATA_W];
          bws_n_r <= wbsel_r[wb_r*`SPD_LANES +: `SPD_LANES];
          wb_r <= wb_r + 2'h1;
          if (wb_r == `SPD_BEAT_LAST) begin
            st_r <= CT_IDLE;
          end
        end
        // No spare encoding; reached only from an unknown state
        default: begin
          st_r <= CT_IDLE;
        end
      endcase
    end
  end

  // Assemble returning beats while the valid flag is high
  assign push = LINK.vld && rb_r == `SPD_BEAT_LAST;
  assign push_data = {LINK.q, asm_r[(`SPD_BURST-1)*`SPD_DATA_W-1:0]};

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pend_r <= 1'b0;
      rb_r <= `SPD_BEAT_FIRST;
      asm_r <= '0;
    end else begin
      if (rd_take) begin
        pend_r <= 1'b1;
      end else if (push) begin
        pend_r <= 1'b0;
      end
      if (LINK.vld) begin
        // Beat order: first beat lands in the lowest word
        asm_r[rb_r*`SPD_DATA_W +: `SPD_DATA_W] <= LINK.q;
        rb_r <= rb_r + 2'h1;
      end
    end
  end

  // Return buffer occupancy
  assign pop = ovld_r && RD_DATA_READY_I;
  assign slot = pop ? cnt_r - CW'(1) : cnt_r;
  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + CW'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - CW'(1);
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cnt_r <= '0;
      ovld_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ovld_r <= cnt_nxt != '0;
    end
  end

  // Buffer entries shift toward the head on each pop
  for (genvar e = 0; e < FIFO_DEPTH; e++) begin : g_ent
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
        ent_r[e] <= '0;
      end else if (push && slot == CW'(e)) begin
        ent_r[e] <= push_data;
      end else if (pop) begin
        if (e < FIFO_DEPTH - 1) begin
          ent_r[e] <= ent_r[(e + 1) % FIFO_DEPTH];
        end
      end
    end
  end

  // Link outputs straight from flops
  assign LINK.k = k_r;
  assign LINK.wsel_n = wsel_n_r;
  assign LINK.rsel_n = rsel_n_r;
  assign LINK.addr = addr_r;
  assign LINK.d = d_r;
  assign LINK.bws_n = bws_n_r;

  // User outputs straight from flops
  assign WR_READY_O = wr_rdy_r;
  assign RD_READY_O = rd_rdy_r;
  assign RD_DATA_O = ent_r[0];
  assign RD_DATA_VALID_O = ovld_r;
endmodule

// ==== tb/spd_link_sva.sv ====
// Checker for the pin link between the SRAM end and the controller end.
// Assumes the bench instantiates it beside the link and wires the signals by name.
`timescale 1ns/1ps
module spd_link_sva (
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  input wire logic k,
  input wire logic wsel_n,
  input wire logic rsel_n,
  input wire spd_pkg::spd_lane_t bws_n,
  input wire logic q_oe,
  input wire logic vld,
  input wire logic echo
);
  import spd_pkg::*;
  // One clock domain for every property
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  // Echo strobe follows the clock level
  echo_tracks_k_a: assert property (echo == k)
    else $error("echo strobe differs from clock level");
  // Selects only in true-edge cycles
  sel_true_edge_a: assert property ((!wsel_n || !rsel_n) |-> k)
    else $error("select outside a true-edge cycle");
  // Write select is a single pulse
  wsel_pulse_a: assert property (!wsel_n |=> wsel_n)
    else $error("write select held too long");
  // Four read beats two cycles after the select
  read_burst_a: assert property ((k && !rsel_n) |-> ##2 (q_oe && vld)[*4])
    else $error("read burst not four beats at latency two");
  // Read bus released after the burst
  read_float_a: assert property ((k && !rsel_n) |-> ##6 (!q_oe && !vld))
    else $error("read bus still driven after burst");
  // Drive starts only from a read select
  read_cause_a: assert property ($rose(q_oe) |-> ($past(k, 2) && !$past(rsel_n, 2)))
    else $error("read drive without a select");
  // Valid flag marks exactly the driven beats
  valid_drive_a: assert property (vld == q_oe)
    else $error("valid flag and drive disagree");
  // First read beat on a true edge
  beat_edge_a: assert property ($rose(vld) |-> (k && echo))
    else $error("first read beat off the true edge");
  // Lane selects idle once the four beats are done
  lane_idle_a: assert property ((k && !wsel_n) |-> ##5 (bws_n == 4'hf))
    else $error("lane selects active outside a write");
endmodule

// ==== tb/tb_split_port_ddr_sram_pins.sv ====
// Bench joining the SRAM end and the controller end through the link.
// Assumes the design files and the checker are compiled before this file.
`timescale 1ns/1ps
module tb_split_port_ddr_sram_pins;
  import spd_pkg::*;
  localparam int AW = 4; // Backed address bits, kept small
  logic clk, rst_n, wr_valid, wr_ready, rd_valid, rd_ready, rdd_valid, rdd_ready;
  logic wr_busy, rd_busy; // Status outputs of the SRAM end
  logic seen; // Read taken while full
  spd_addr_t wr_addr, rd_addr, wa, ra, a; // Request and last link addresses
  spd_burst_t wr_data, rd_data, wd; // User bursts and last write burst
  spd_bsel_t wr_bsel_n, ws, sel; // Lane selects, last write selects, next random selects
  spd_word_t mem [0:(1<<(AW+2))-1]; // Reference array
  spd_burst_t exp_q[$]; // Bursts due at the user side
  int err_count, n_tests, wb, rb, i, n;
  integer seed;

  spd_link_if lnk ();
  spd_sram_dev #(.MEM_AW(AW)) i_spd_sram_dev (.SYS_CLK_I(clk), .ARST_N_I(rst_n),
    .LINK(lnk), .WR_BUSY_O(wr_busy), .RD_BUSY_O(rd_busy));
  spd_sram_ctl i_spd_sram_ctl (.SYS_CLK_I(clk), .ARST_N_I(rst_n), .LINK(lnk),
    .WR_VALID_I(wr_valid), .WR_READY_O(wr_ready), .WR_ADDR_I(wr_addr),
    .WR_DATA_I(wr_data), .WR_BSEL_N_I(wr_bsel_n), .RD_VALID_I(rd_valid),
    .RD_READY_O(rd_ready), .RD_ADDR_I(rd_addr), .RD_DATA_O(rd_data),
    .RD_DATA_VALID_O(rdd_valid), .RD_DATA_READY_I(rdd_ready));
  spd_link_sva u_chk (.SYS_CLK_I(clk), .ARST_N_I(rst_n), .k(lnk.k), .wsel_n(lnk.wsel_n),
    .rsel_n(lnk.rsel_n), .bws_n(lnk.bws_n), .q_oe(lnk.q_oe), .vld(lnk.vld),
    .echo(lnk.echo));

  // Clock at 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk_word(input spd_word_t got, input spd_word_t exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_burst(input spd_burst_t got, input spd_burst_t exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: burst got %h want %h", $time, got, exp);
    end
  endtask

  // Enabled lanes take new data, the rest keep old
  function automatic spd_word_t merge(spd_word_t old, spd_word_t nw, spd_lane_t sel_n);
    spd_word_t r;
    r = old;
    for (int l = 0; l < 4; l++) begin
      if (!sel_n[l]) r[9*l +: 9] = nw[9*l +: 9];
    end
    return r;
  endfunction

  // Expected user burst, beat 0 lowest
  function automatic spd_burst_t exp_burst(spd_addr_t ad);
    spd_burst_t r;
    for (int b = 0; b < 4; b++) r[36*b +: 36] = mem[{ad[AW-1:0], 2'(b)}];
    return r;
  endfunction

  function automatic spd_burst_t rnd_burst();
    return spd_burst_t'({$random(seed), $random(seed), $random(seed), $random(seed),
      $random(seed)});
  endfunction

  // Present a write and hold it until taken
  task automatic do_write(input spd_addr_t ad, input spd_burst_t dat, input spd_bsel_t sel);
    int t;
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_addr <= ad;
    wr_data <= dat;
    wr_bsel_n <= sel;
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (wr_ready !== 1'b1 && t < 60);
    chk_word({35'h0, wr_ready}, 36'h1, "write taken");
    wa = ad;
    wd = dat;
    ws = sel;
    @(posedge clk);
    wr_valid <= 1'b0;
    for (int b = 0; b < 4; b++) begin
      mem[{ad[AW-1:0], 2'(b)}] = merge(mem[{ad[AW-1:0], 2'(b)}], dat[36*b +: 36],
        sel[4*b +: 4]);
    end
  endtask

  // Present a read and hold it until taken
  task automatic do_read(input spd_addr_t ad);
    int t;
    @(posedge clk);
    rd_valid <= 1'b1;
    rd_addr <= ad;
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (rd_ready !== 1'b1 && t < 60);
    chk_word({35'h0, rd_ready}, 36'h1, "read taken");
    @(posedge clk);
    rd_valid <= 1'b0;
    exp_q.push_back(exp_burst(ad));
  endtask

  // Take buffered bursts and compare
  task automatic drain(input int cnt);
    int t;
    @(posedge clk);
    rdd_ready <= 1'b1;
    repeat (cnt) begin
      t = 0;
      do begin
        @(negedge clk);
        t++;
      end while (rdd_valid !== 1'b1 && t < 60);
      chk_burst(rd_data, exp_q.pop_front());
      @(posedge clk);
    end
    rdd_ready <= 1'b0;
  endtask

  // Link watcher: write beats, read beats, floating bus
  always @(negedge clk) begin
    if (rst_n === 1'b1) begin
      if (lnk.q_oe === 1'b0) begin
        chk_word(lnk.q, 36'h0, "bus released");
        chk_word({35'h0, rd_busy}, 36'h0, "read idle");
      end
      if (lnk.k === 1'b1 && lnk.wsel_n === 1'b0) begin
        chk_word({17'h0, lnk.addr}, {17'h0, wa}, "write address");
        chk_word({35'h0, wr_busy}, 36'h0, "write idle at select");
        wb = 0;
      end else if (wb < 4) begin
        chk_word(lnk.d, wd[36*wb +: 36], "write beat");
        chk_word({35'h0, wr_busy}, 36'h1, "write busy");
        chk_word({32'h0, lnk.bws_n}, {32'h0, ws[4*wb +: 4]}, "lane select");
        wb++;
      end
      if (lnk.k === 1'b1 && lnk.rsel_n === 1'b0) begin
        ra = lnk.addr;
        rb = 0;
      end
      if (lnk.vld === 1'b1) begin
        chk_word(lnk.q, mem[{ra[AW-1:0], rb[1:0]}], "read beat");
        chk_word({35'h0, rd_busy}, 36'h1, "read busy");
        rb++;
      end
    end
  end

  task automatic conclude();
    $display("Mismatches %0d, comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    #1000000;
    err_count++;
    conclude();
  end

  // Main sequence
  initial begin
    seed = 97639;
    err_count = 0;
    n_tests = 0;
    rb = 0;
    sel = '1;
    wb = 4;
    {rst_n, wr_valid, rd_valid, rdd_ready} = 4'h0;
    {wr_addr, rd_addr, wa, ra} = '0;
    {wr_data, wd} = '0;
    {wr_bsel_n, ws} = '1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // Fill every backed location, all lanes on
    for (i = 0; i < 16; i++) do_write(spd_addr_t'(i), rnd_burst(), '0);
    // Random writes and reads, first write with no lane enabled
    for (i = 0; i < 50; i++) begin
      n = $random(seed);
      a = spd_addr_t'(n[AW+1:2]);
      sel = (i == 0) ? '1 : spd_bsel_t'($random(seed));
      if (n[0] || i == 0) do_write(a, rnd_burst(), sel);
      if (n[1] || i == 0) begin
        do_read(a);
        drain(1);
      end
    end
    // Stalled user: buffer fills, further reads refused
    do_read(spd_addr_t'(3));
    do_read(spd_addr_t'(5));
    @(posedge clk);
    rd_valid <= 1'b1;
    rd_addr <= spd_addr_t'(7);
    seen = 1'b0;
    repeat (20) begin
      @(negedge clk);
      if (rd_ready === 1'b1) seen = 1'b1;
    end
    chk_word({35'h0, seen}, 36'h0, "read taken while full");
    @(posedge clk);
    rd_valid <= 1'b0;
    drain(2);
    repeat (10) @(posedge clk);
    conclude();
  end
endmodule
